// ### common/scr_pkg.sv
/*
  Shared constants, types and the CRC step for the serial command port
  and its conversion restart sequencer.
  Assumes clk is the master clock and one modulator period lasts one clk.
*/
package scr_pkg;

  // restart timing, in master-clock periods
  localparam int SYNC_CYCLES    = 2;    // reset-to-restart synchronisation
  localparam int STARTUP_DMCLK  = 256;  // converter start-up time, modulator periods
  localparam int CLK_PER_DMCLK  = 1;    // clk periods per modulator period
  localparam int STARTUP_CYCLES = STARTUP_DMCLK * CLK_PER_DMCLK;

  // register addresses
  localparam logic [3:0] ADDR_DATA   = 4'h0;  // conversion data, read only
  localparam logic [3:0] ADDR_CFG0   = 4'h1;  // main configuration register
  localparam logic [3:0] ADDR_CFG2   = 4'h3;  // gain and bias current
  localparam logic [3:0] ADDR_CFG3   = 4'h4;  // digital formats
  localparam logic [3:0] ADDR_IRQ    = 4'h5;  // interface enables
  localparam logic [3:0] ADDR_SCAN   = 4'h7;  // scan channel mask
  localparam logic [3:0] ADDR_TIMER  = 4'h8;  // inter-cycle delay
  localparam logic [3:0] ADDR_RSV_B  = 4'hB;  // reserved
  localparam logic [3:0] ADDR_RSV_C  = 4'hC;  // reserved
  localparam logic [3:0] ADDR_LOCK   = 4'hD;  // write lock key
  localparam logic [3:0] ADDR_CRC_HI = 4'hE;  // map checksum, high byte
  localparam logic [3:0] ADDR_CRC_LO = 4'hF;  // map checksum, low byte

  // field positions
  localparam int CFG0_SLOW_HI = 7;  // top bits, clock and current-source select
  localparam int CFG0_SLOW_LO = 2;
  localparam int BIAS_CURRENT_A_HI     = 3;  // bias_current_a field
  localparam int BIAS_CURRENT_A_LO     = 2;
  localparam int IRQ_FAST_BIT = 0;  // fast command enable
  localparam int IRQ_STP_BIT  = 1;  // start_pulse_enable
  localparam int IRQ_CRC_BIT  = 2;  // checksum on reads

  // reset values and keys
  localparam logic [7:0]  REG_RESET  = 8'h00;
  localparam logic [7:0]  IRQ_RESET  = 8'h01;
  localparam logic [7:0]  LOCK_KEY   = 8'hA5;
  localparam logic [7:0]  LOCK_RESET = 8'hA5;
  localparam logic [15:0] CRC_POLY   = 16'h8005;

  // conversion mode codes
  localparam logic [1:0] MODE_CONV     = 2'h3;
  localparam logic [1:0] MODE_STANDBY  = 2'h2;
  localparam logic [1:0] MODE_SHUTDOWN = 2'h0;

  // fast command codes
  localparam logic [3:0] FC_START    = 4'hA;
  localparam logic [3:0] FC_STANDBY  = 4'hB;
  localparam logic [3:0] FC_SHUTDOWN = 4'hC;
  localparam logic [3:0] FC_FULL_OFF = 4'hD;
  localparam logic [3:0] FC_RESET    = 4'hE;

  // command types
  typedef enum logic [1:0] {
    CT_FAST   = 2'b00,
    CT_STATIC = 2'b01,
    CT_WRITE  = 2'b10,
    CT_INC    = 2'b11
  } scr_ctype_t;

  // restart sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SYNC  = 2'b01,
    ST_SETUP = 2'b10
  } scr_seq_t;

  // one byte through the checksum, msb first
  function automatic logic [15:0] scr_crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      if (r[15] ^ d[i]) begin
        r = {r[14:0], 1'b0} ^ CRC_POLY;
      end else begin
        r = {r[14:0], 1'b0};
      end
    end
    return r;
  endfunction : scr_crc_byte

endpackage : scr_pkg

// ### core/scr_restart_seq.sv
/*
  Conversion reset and restart sequencer on the master clock.
  Assumes requests are single-cycle pulses already in the clk domain.
*/
`timescale 1ns/1ps
module scr_restart_seq import scr_pkg::*; #(
  parameter int SETUP_CYC = STARTUP_CYCLES  // start-up time in clk cycles
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // restart request
  input  wire logic req,
  input  wire logic req_delayed,
  input  wire logic req_scan,
  input  wire logic stp_en,
  // sequencing
  output wire logic conv_reset,
  output logic      phase_reset,
  output logic      scan_restart,
  output logic      start_pulse,
  output wire logic setup_busy
);

  localparam int CW = $clog2(SETUP_CYC + SYNC_CYCLES + 1);
  localparam int IMM_END   = SYNC_CYCLES + 1;
  localparam int SETUP_END = SYNC_CYCLES + SETUP_CYC + 1;

  scr_seq_t     state;  // sequencer state
  logic [CW-1:0] cnt;   // cycles within state
  logic          dly;   // start-up wait pending
  logic          end_evt;

  // last cycle of a sequence
  assign end_evt = !req && ((state == ST_SYNC && cnt == CW'(SYNC_CYCLES - 1) && !dly) ||
                            (state == ST_SETUP && cnt == CW'(SETUP_CYC - 1)));

  // held in reset from the request on, mode is not looked at
  assign conv_reset = (state != ST_IDLE);
  assign setup_busy = (state == ST_SETUP);

  // state walk; a new request restarts the walk
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= ST_IDLE;
      cnt   <= '0;
      dly   <= 1'b0;
    end else if (req) begin
      state <= ST_SYNC;
      cnt   <= '0;
      dly   <= req_delayed;
    end else begin
      case (state)
        ST_SYNC: begin
          if (cnt == CW'(SYNC_CYCLES - 1)) begin
            state <= dly ? ST_SETUP : ST_IDLE;
            cnt   <= '0;
          end else begin
            cnt <= cnt + CW'(1);
          end
        end
        ST_SETUP: begin
          if (cnt == CW'(SETUP_CYC - 1)) begin
            state <= ST_IDLE;
            cnt   <= '0;
          end else begin
            cnt <= cnt + CW'(1);
          end
        end
        default: begin
          state <= ST_IDLE;
          cnt   <= '0;
        end
      endcase
    end
  end

  // pulses: phases at once, start mark at the real restart
  always_ff @(posedge clk) begin
    if (srst) begin
      phase_reset  <= 1'b0;
      scan_restart <= 1'b0;
      start_pulse  <= 1'b0;
    end else begin
      phase_reset  <= req;
      scan_restart <= req && req_scan && !req_delayed;
      start_pulse  <= end_evt && stp_en;
    end
  end

  // helper: cycles since the last request
  logic [15:0] len;
  logic        last_dly;
  always_ff @(posedge clk) begin
    if (srst) begin
      len      <= 16'h0000;
      last_dly <= 1'b0;
    end else begin
      len      <= req ? 16'h0001 : (len == 16'hFFFF ? len : len + 16'h0001);
      last_dly <= req ? req_delayed : last_dly;
    end
  end

  sequence s_imm;
    (req && !req_delayed) ##1 (!req) [*2];
  endsequence
  sequence s_imm_stp;
    (req && !req_delayed && stp_en) ##1 (!req) [*2];
  endsequence

  a_reset_at_once: assert property (@(posedge clk) disable iff (srst) req |=> conv_reset)
    else $error("conversion not reset after request");
  a_sync_release: assert property (@(posedge clk) disable iff (srst) s_imm |=> !conv_reset)
    else $error("immediate restart not released after two periods");
  a_start_mark: assert property (@(posedge clk) disable iff (srst) s_imm_stp |=> start_pulse)
    else $error("start pulse missing after restart");
  a_seq_length: assert property (@(posedge clk) disable iff (srst)
    $fell(conv_reset) |-> len == (last_dly ? 16'(SETUP_END) : 16'(IMM_END)))
    else $error("restart sequence length wrong");
  a_scan_kept: assert property (@(posedge clk) disable iff (srst) req && req_delayed |=> !scan_restart)
    else $error("scan sequence restarted by delayed group");
  a_phase_back: assert property (@(posedge clk) disable iff (srst) req |=> phase_reset)
    else $error("clock phases not reset");

endmodule : scr_restart_seq

// ### core/scr_spi_port.sv
/*
  Serial register port with write-triggered conversion restart.
  Assumes clk is the master clock, well above the serial clock rate.
*/
`timescale 1ns/1ps
module scr_spi_port import scr_pkg::*; #(
  parameter logic [1:0] DEV_ADDR  = 2'h1,  // hard-wired device address, arbitrary
  parameter int         SETUP_CYC = STARTUP_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        por_active,
  // serial pins
  input  wire logic        cs_n,
  input  wire logic        sck,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             sdo_oe,
  // converter side
  input  wire logic [7:0]  adc_data,
  input  wire logic [2:0]  status_bits,
  input  wire logic        in_cycle_delay,
  input  wire logic        crc_flag_clear,
  // restart sequencing
  output wire logic        conv_reset,
  output wire logic        phase_reset,
  output wire logic        scan_restart,
  output wire logic        start_pulse,
  output wire logic        setup_busy,
  // configuration and state
  output wire logic [7:0]  main_cfg,
  output wire logic        scan_mode,
  output wire logic        locked,
  output logic      [15:0] config_crc,
  output logic             crc_changed,
  output logic             full_reset
);

  // pin synchronisers, two flops each; cs idles high
  localparam logic [3:0] SYNC_INIT = 4'h4;
  logic [3:0] pin_raw;  // {por, cs, sck, sdi}
  logic [3:0] s1;       // first stage, read only by s2
  logic [3:0] s2;       // usable stage
  assign pin_raw = {por_active, cs_n, sck, sdi};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (srst) begin
          s1[gi] <= SYNC_INIT[gi];
          s2[gi] <= SYNC_INIT[gi];
        end else begin
          s1[gi] <= pin_raw[gi];
          s2[gi] <= s1[gi];
        end
      end
    end
  endgenerate

  logic por_s, cs_s, sck_s, sdi_s;
  logic sck_d, cs_d;  // previous synced levels
  assign {por_s, cs_s, sck_s, sdi_s} = s2;

  // edge detect on the second stage only
  always_ff @(posedge clk) begin
    if (srst) begin
      sck_d <= 1'b0;
      cs_d  <= 1'b1;
    end else begin
      sck_d <= sck_s;
      cs_d  <= cs_s;
    end
  end

  logic spi_rst, spi_idle, rise, fall, cs_fall;
  assign spi_rst  = srst || por_s;
  assign spi_idle = spi_rst || cs_s;
  assign rise     = sck_s && !sck_d;
  assign fall     = !sck_s && sck_d;
  assign cs_fall  = !cs_s && cs_d;

  // serial state
  logic [2:0]  bit_cnt;    // bit within byte
  logic [7:0]  rx;         // incoming bits
  logic        cmd_done;   // command byte taken
  logic        dead;       // address mismatch or fast command
  logic        seen_rise;  // first rising edge seen
  logic [3:0]  addr;       // current register
  scr_ctype_t  ctype;      // command type
  logic [7:0]  tx;         // outgoing bits
  logic [1:0]  rd_phase;   // 0 data, 1 checksum high, 2 checksum low
  logic [15:0] crc_acc;    // read checksum

  logic [7:0]  next_rx;
  logic        byte_done;
  logic [3:0]  cur_addr;
  scr_ctype_t  cur_type;
  logic        is_read;
  logic [7:0]  rd_byte;
  logic [7:0]  status;
  logic        addr_miss;

  // register map, fixed width per word
  logic [7:0] regs [16];
  logic       unlocked;

  assign next_rx   = {rx[6:0], sdi_s};
  assign byte_done = rise && bit_cnt == 3'h7;
  assign cur_addr  = cmd_done ? addr : next_rx[5:2];
  assign cur_type  = cmd_done ? ctype : scr_ctype_t'(next_rx[1:0]);
  assign is_read   = cur_type == CT_STATIC || cur_type == CT_INC;
  assign addr_miss = rise && !cmd_done && bit_cnt == 3'h1 && next_rx[1:0] != DEV_ADDR;
  // top two bits zero, then address echo and flags
  assign status    = {2'b00, DEV_ADDR, ~DEV_ADDR[0], status_bits};
  assign unlocked  = regs[ADDR_LOCK] == LOCK_KEY;

  // read source
  always_comb begin
    case (cur_addr)
      ADDR_DATA:   rd_byte = adc_data;
      ADDR_CRC_HI: rd_byte = config_crc[15:8];
      ADDR_CRC_LO: rd_byte = config_crc[7:0];
      default:     rd_byte = regs[cur_addr];
    endcase
  end

  // command, address and read stream
  always_ff @(posedge clk) begin
    if (spi_idle) begin
      bit_cnt   <= 3'h0;
      rx        <= 8'h00;
      cmd_done  <= 1'b0;
      dead      <= 1'b0;
      seen_rise <= 1'b0;
      addr      <= 4'h0;
      ctype     <= CT_FAST;
      tx        <= 8'h00;
      rd_phase  <= 2'h0;
      crc_acc   <= 16'h0000;
    end else if (cs_fall) begin
      tx <= {status[6:0], 1'b0};  // status first, msb already out
    end else begin
      if (rise) begin
        seen_rise <= 1'b1;
        rx        <= next_rx;
        bit_cnt   <= bit_cnt + 3'h1;
        if (addr_miss) begin
          dead <= 1'b1;
        end
      end
      if (byte_done && !cmd_done) begin
        cmd_done <= 1'b1;
        ctype    <= cur_type;
        addr     <= cur_addr;
        if (cur_type == CT_FAST) begin
          dead <= 1'b1;
        end
      end
      if (byte_done && cmd_done && ctype == CT_WRITE) begin
        addr <= addr + 4'h1;  // incremental write
      end
      if (byte_done && !dead && is_read) begin
        case (rd_phase)
          2'h0: begin
            tx      <= rd_byte;
            crc_acc <= scr_crc_byte(crc_acc, rd_byte);
            addr    <= (cur_type == CT_INC) ? cur_addr + 4'h1 : cur_addr;
            if (regs[ADDR_IRQ][IRQ_CRC_BIT] && (cur_type == CT_STATIC || cur_addr == ADDR_CRC_LO)) begin
              rd_phase <= 2'h1;
            end
          end
          2'h1: begin
            tx       <= crc_acc[15:8];
            rd_phase <= 2'h2;
          end
          default: begin
            tx       <= crc_acc[7:0];
            rd_phase <= 2'h0;
            crc_acc  <= 16'h0000;
          end
        endcase
      end
      // shift only after the first sampling edge, so mode 1,1 keeps bit 7
      if (fall && seen_rise) begin
        tx <= {tx[6:0], 1'b0};
      end
    end
  end

  // output pin and its enable
  always_ff @(posedge clk) begin
    if (spi_idle) begin
      sdo    <= 1'b0;
      sdo_oe <= 1'b0;
    end else if (cs_fall) begin
      sdo    <= status[7];
      sdo_oe <= 1'b1;
    end else begin
      if (addr_miss) begin
        sdo_oe <= 1'b0;
      end else if (byte_done && !cmd_done && !is_read) begin
        sdo_oe <= 1'b0;  // fast and write leave the line free
      end
      if (fall && seen_rise) begin
        sdo <= tx[7];
      end
    end
  end

  // write and fast command strobes
  logic wr_try, wr_fire, fast_go;
  logic [7:0] wr_data;
  assign wr_data = next_rx;
  assign wr_try  = byte_done && cmd_done && !dead && ctype == CT_WRITE;
  // lock register itself stays writable so the key can be restored
  assign wr_fire = wr_try && addr != ADDR_DATA && addr != ADDR_CRC_HI && addr != ADDR_CRC_LO &&
                   (unlocked || addr == ADDR_LOCK);
  assign fast_go = byte_done && !cmd_done && !dead && cur_type == CT_FAST &&
                   regs[ADDR_IRQ][IRQ_FAST_BIT];

  // register map updates
  always_ff @(posedge clk) begin
    if (srst || (fast_go && next_rx[5:2] == FC_RESET)) begin
      for (int i = 0; i < 16; i++) begin
        regs[i] <= (i == ADDR_IRQ) ? IRQ_RESET : ((i == ADDR_LOCK) ? LOCK_RESET : REG_RESET);
      end
    end else begin
      if (wr_fire) begin
        regs[addr] <= wr_data;
      end
      if (fast_go) begin
        case (next_rx[5:2])
          FC_START:    regs[ADDR_CFG0][1:0] <= MODE_CONV;
          FC_STANDBY:  regs[ADDR_CFG0][1:0] <= MODE_STANDBY;
          FC_SHUTDOWN: regs[ADDR_CFG0][1:0] <= MODE_SHUTDOWN;
          FC_FULL_OFF: regs[ADDR_CFG0]      <= REG_RESET;
          default:     ;  // other codes ignored
        endcase
      end
    end
  end

  // full reset pulse to the rest of the device
  always_ff @(posedge clk) begin
    if (srst) begin
      full_reset <= 1'b0;
    end else begin
      full_reset <= fast_go && next_rx[5:2] == FC_RESET;
    end
  end

  assign main_cfg  = regs[ADDR_CFG0];
  assign scan_mode = regs[ADDR_SCAN] != 8'h00;
  assign locked    = !unlocked;

  // restart classification of each accepted write
  logic seq_req, seq_dly, seq_scan;
  always_comb begin
    seq_req  = fast_go && next_rx[5:2] == FC_START;
    seq_dly  = 1'b0;
    seq_scan = 1'b0;
    if (wr_fire) begin
      case (addr)
        ADDR_CFG0: begin
          seq_req = 1'b1;
          seq_dly = wr_data[CFG0_SLOW_HI:CFG0_SLOW_LO] !=
                    regs[ADDR_CFG0][CFG0_SLOW_HI:CFG0_SLOW_LO];
        end
        ADDR_CFG2: begin
          seq_req = 1'b1;
          seq_dly = wr_data[BIAS_CURRENT_A_HI:BIAS_CURRENT_A_LO] != regs[ADDR_CFG2][BIAS_CURRENT_A_HI:BIAS_CURRENT_A_LO];
        end
        ADDR_RSV_B, ADDR_RSV_C: begin
          seq_req = 1'b1;
          seq_dly = 1'b1;
        end
        ADDR_SCAN: begin
          if (!scan_mode) begin
            seq_req  = wr_data != 8'h00;
            seq_scan = wr_data != 8'h00;
          end else begin
            seq_req  = !in_cycle_delay;
            seq_scan = !in_cycle_delay;
          end
        end
        ADDR_TIMER: begin
          seq_req  = scan_mode && in_cycle_delay;
          seq_scan = scan_mode && in_cycle_delay;
        end
        ADDR_CFG3, ADDR_IRQ, ADDR_LOCK: ;  // digital settings, no restart
        default: seq_req = 1'b1;
      endcase
    end
  end

  // sequencer; a fixed two-period sync, never the stretched four
  scr_restart_seq #(
    .SETUP_CYC (SETUP_CYC)
  ) u_seq (
    .clk          (clk),
    .srst         (srst),
    .req          (seq_req),
    .req_delayed  (seq_dly),
    .req_scan     (seq_scan),
    .stp_en       (regs[ADDR_IRQ][IRQ_STP_BIT]),
    .conv_reset   (conv_reset),
    .phase_reset  (phase_reset),
    .scan_restart (scan_restart),
    .start_pulse  (start_pulse),
    .setup_busy   (setup_busy)
  );

  // background checksum of writable registers while locked
  logic [3:0]  bg_idx;
  logic [15:0] bg_acc, bg_next;
  logic        bg_valid;
  assign bg_next = scr_crc_byte(bg_acc, regs[bg_idx]);
  always_ff @(posedge clk) begin
    if (srst || unlocked) begin
      bg_idx   <= ADDR_CFG0;
      bg_acc   <= 16'h0000;
      bg_valid <= 1'b0;
    end else if (bg_idx == ADDR_LOCK) begin
      bg_idx   <= ADDR_CFG0;
      bg_acc   <= 16'h0000;
      bg_valid <= 1'b1;
    end else begin
      bg_idx <= bg_idx + 4'h1;
      bg_acc <= bg_next;
    end
  end

  // result and sticky change flag; a new change beats the clear
  always_ff @(posedge clk) begin
    if (srst) begin
      config_crc  <= 16'h0000;
      crc_changed <= 1'b0;
    end else begin
      if (!unlocked && bg_idx == ADDR_LOCK) begin
        config_crc <= bg_next;
      end
      if (!unlocked && bg_idx == ADDR_LOCK && bg_valid && bg_next != config_crc) begin
        crc_changed <= 1'b1;
      end else if (crc_flag_clear) begin
        crc_changed <= 1'b0;
      end
    end
  end

  a_cs_float: assert property (@(posedge clk) disable iff (srst) cs_s && cs_d |-> !sdo_oe)
    else $error("output driven while deselected");
  a_lead_zero: assert property (@(posedge clk) disable iff (spi_rst) cs_fall |=> sdo_oe && !sdo)
    else $error("output not low after select");
  a_addr_float: assert property (@(posedge clk) disable iff (spi_rst) addr_miss |=> (!sdo_oe) [*3])
    else $error("output driven after address mismatch");
  a_lock_guard: assert property (@(posedge clk) disable iff (srst)
    wr_try && !unlocked && addr != ADDR_LOCK |=> regs[$past(addr)] == $past(regs[addr]))
    else $error("write taken while locked");
  a_timer_quiet: assert property (@(posedge clk) disable iff (srst)
    wr_fire && addr == ADDR_TIMER && !(scan_mode && in_cycle_delay) |-> !seq_req)
    else $error("timer write restarted outside delay");
  a_scan_enter: assert property (@(posedge clk) disable iff (srst)
    wr_fire && addr == ADDR_SCAN && !scan_mode && wr_data != 8'h00 |-> seq_req ##1 scan_restart)
    else $error("scan entry did not restart sequence");

endmodule : scr_spi_port

// ### test/scr_spi_host.sv
/*
  Host controller model for the serial command port.
  Assumes clk runs at 25 ns; sck is made from it at 200 ns per bit.
*/
`timescale 1ns/1ps
module scr_spi_host (
  // clock
  input  wire logic clk,
  // serial pins
  output logic      cs_n,
  output logic      sck,
  output logic      sdi,
  input  wire logic sdo
);
  // deselected at power-up
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    sdi  = 1'b0;
  end
  // one frame of n bytes from the top of tx; sdo taken at each rise
  task automatic xfer(input logic m11, input int n, input logic [23:0] tx, output logic [23:0] rx);
    rx = 24'h000000;
    sck <= m11;  // idle level set only while deselected
    repeat (4) @(posedge clk);
    cs_n <= 1'b0;  // each frame starts afresh
    repeat (4) @(posedge clk);
    for (int i = 0; i < 8 * n; i++) begin
      sck <= 1'b0;  // data changes on the fall
      sdi <= tx[23-i];  // msb first
      repeat (4) @(posedge clk);
      sck <= 1'b1;
      rx[23-i] = sdo;  // half period of settling before the rise
      repeat (4) @(posedge clk);
    end
    sck  <= m11;
    cs_n <= 1'b1;  // frame always closed by a rise
    sdi  <= ~sdi;  // released line keeps no stale level
    repeat (4) @(posedge clk);
  endtask : xfer
endmodule : scr_spi_host

// ### test/scr_spi_port_tb_top.sv
/*
  Bench: table of register writes against restart pulse counts,
  then read, mismatch, fast command, lock and power-on cases.
  Assumes the host model drives the pins at 200 ns per bit.
*/
`timescale 1ns/1ps
module scr_spi_port_tb_top import scr_pkg::*;;
  // one write and the restart it should cause
  typedef struct packed {
    logic [3:0] a; logic [7:0] v; logic d;
    logic [4:0] cr; logic [3:0] su; logic sc;
  } scr_row_t;
  // bench-driven inputs
  logic        clk  = 1'b0;
  logic        srst = 1'b1;
  logic        por  = 1'b0;
  logic        icd  = 1'b0;
  logic        clr  = 1'b1;
  logic        pcr  = 1'b0;
  logic [23:0] rx;
  // design outputs
  wire logic        cs_n, sck, sdi, sdo_q, sdo_oe, cr, ph, sc, sp, su, smode, lk, chg, frst;
  wire logic [7:0]  cfg;
  wire logic [15:0] crc;
  int n_fail = 0, check_count = 0, ncr, nsu, nsc, nph, nsp, nfr;
  // start-up shortened to 8, so a delayed restart holds reset 10 cycles
  scr_row_t rows [17] = '{
    '{ADDR_IRQ, 8'h03, 1'b0, 5'h00, 4'h0, 1'b0}, '{ADDR_CFG0, 8'hC3, 1'b0, 5'h0A, 4'h8, 1'b0},
    '{ADDR_CFG0, 8'hC3, 1'b0, 5'h02, 4'h0, 1'b0}, '{ADDR_CFG0, 8'h02, 1'b0, 5'h0A, 4'h8, 1'b0},
    '{ADDR_CFG0, 8'h03, 1'b0, 5'h02, 4'h0, 1'b0}, '{ADDR_CFG2, 8'h0C, 1'b0, 5'h0A, 4'h8, 1'b0},
    '{ADDR_CFG2, 8'h3C, 1'b0, 5'h02, 4'h0, 1'b0}, '{ADDR_RSV_B, 8'h00, 1'b0, 5'h0A, 4'h8, 1'b0},
    '{ADDR_RSV_C, 8'h00, 1'b0, 5'h0A, 4'h8, 1'b0}, '{ADDR_CFG3, 8'h55, 1'b0, 5'h00, 4'h0, 1'b0},
    '{ADDR_TIMER, 8'h10, 1'b0, 5'h00, 4'h0, 1'b0}, '{ADDR_SCAN, 8'h01, 1'b0, 5'h02, 4'h0, 1'b1},
    '{ADDR_TIMER, 8'h20, 1'b0, 5'h00, 4'h0, 1'b0}, '{ADDR_SCAN, 8'h03, 1'b0, 5'h02, 4'h0, 1'b1},
    '{ADDR_SCAN, 8'h07, 1'b1, 5'h00, 4'h0, 1'b0}, '{ADDR_TIMER, 8'h30, 1'b1, 5'h02, 4'h0, 1'b1},
    '{ADDR_CFG2, 8'h00, 1'b0, 5'h0A, 4'h8, 1'b0}};
  always #12.5 clk = ~clk;
  // pulse and level counters per write; start pulse counted only where reset just fell
  always @(posedge clk) begin
    if (clr) begin
      {ncr, nsu, nsc, nph, nsp, nfr} = '0;
    end else begin
      ncr += cr; nsu += su; nsc += sc; nph += ph; nsp += (sp && !cr && pcr); nfr += frst;
    end
    pcr = cr;
  end
  scr_spi_host i_scr_spi_host (.clk(clk), .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo(sdo_oe ? sdo_q : 1'bz));
  scr_spi_port #(.SETUP_CYC(8)) i_scr_spi_port (
    .clk(clk), .srst(srst), .por_active(por), .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo(sdo_q),
    .sdo_oe(sdo_oe), .adc_data(8'h3C), .status_bits(3'h5), .in_cycle_delay(icd), .crc_flag_clear(1'b0),
    .conv_reset(cr), .phase_reset(ph), .scan_restart(sc), .start_pulse(sp), .setup_busy(su),
    .main_cfg(cfg), .scan_mode(smode), .locked(lk), .config_crc(crc), .crc_changed(chg), .full_reset(frst));
  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  // counted frame: counters cleared first, restart given time to finish
  task automatic wr(input int n, input logic [7:0] cmd, input logic [7:0] v, input logic m);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    i_scr_spi_host.xfer(m, n, {cmd, v, 8'h00}, rx);
    repeat (16) @(posedge clk);
  endtask : wr
  task automatic rs(input int c, input int s, input logic q);
    chk(ncr, c);
    chk(nsu, s);
    chk(nsc, q);
    chk(nph, c > 0);
    chk(nsp, c > 0);
  endtask : rs
  task automatic stop_test();
    if (n_fail == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    chk({cfg, lk, sdo_oe, cr}, 11'h000);
    foreach (rows[i]) begin
      icd <= rows[i].d;
      wr(2, {2'h1, rows[i].a, 2'h2}, rows[i].v, i % 2);  // both modes
      rs(rows[i].cr, rows[i].su, rows[i].sc);
    end
    chk({smode, chg}, 2'b10);
    i_scr_spi_host.xfer(1'b0, 2, 24'h450000, rx);
    chk(rx[23:8], 16'h1503);
    wr(2, 8'h86, 8'hFF, 1'b0);
    rs(0, 0, 1'b0);
    wr(1, 8'h68, 8'h00, 1'b1);
    rs(2, 0, 1'b0);
    wr(2, 8'h76, 8'h00, 1'b0);
    wr(2, 8'h46, 8'hFF, 1'b0);
    chk({lk, cfg}, 9'h103);
    wr(2, 8'h76, 8'hA5, 1'b0);
    por <= 1'b1;
    wr(2, 8'h46, 8'hFF, 1'b0);
    chk({lk, cfg}, 9'h003);
    por <= 1'b0;
    wr(1, 8'h78, 8'h00, 1'b0);
    chk(cfg, 8'h00);
    chk(nfr, 1);
    stop_test();
  end
endmodule : scr_spi_port_tb_top
